//--- common/cts_cfg.svh
// Constants for the transfer, zero-compare and addressing-mode core.
// Assumes inclusion by cts_pkg and the testbench, by bare name.
// What this block does
// - Zero-compare sets N,Z, clears V only.
// - Wait clears I, halts, one byte.
// - Flag load two cycles, byte copies one.
// - Index pair is SP+1; SP is pair-1.
// - Indexed no offset uses pair directly.
// - One offset byte added to pair.
// - Two offset bytes, high first, added.
// - Access at pair, then pair plus one.
// - Pair plus offset byte, then increment pair.
// - Prefixed forms add a one-byte (zero-compare) or two-byte (load) offset to SP.
// - Page-zero source byte copied to page-zero destination.
// - Immediate byte stored at page-zero destination.
// - Read at pair, write page zero, increment.
// - Read page zero, write at pair, increment.
// - Full address fetched high byte first.
// - Page-zero field then signed branch displacement.
// - Zero-compare cycle counts per addressing form.
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH
// Opcodes.
`define CTS_OP_PREFIX   8'h9E
`define CTS_OP_TAP      8'h84
`define CTS_OP_F2A      8'h85
`define CTS_OP_A2X      8'h97
`define CTS_OP_X2A      8'h9F
`define CTS_OP_S2X      8'h95
`define CTS_OP_X2S      8'h94
`define CTS_OP_WAIT     8'h8F
`define CTS_OP_ZC_PZ    8'h3D
`define CTS_OP_ZC_A     8'h4D
`define CTS_OP_ZC_X     8'h5D
`define CTS_OP_ZC_OF1   8'h6D
`define CTS_OP_ZC_NOF   8'h7D
`define CTS_OP_ZC_SO1   8'h6D
`define CTS_OP_LD_FUL   8'hC6
`define CTS_OP_LD_OF2   8'hD6
`define CTS_OP_LD_SO2   8'hD6
`define CTS_OP_LD_IXP   8'hC8
`define CTS_OP_LD_IX1P  8'hC9
`define CTS_OP_MOV_PP   8'h4E
`define CTS_OP_MOV_LP   8'h6E
`define CTS_OP_MOV_IXPD 8'h7E
`define CTS_OP_MOV_DIXP 8'h5E
`define CTS_OP_CBEQ     8'h31
// Cycle counts per instruction.
`define CTS_CYC_TAP     3'h2
`define CTS_CYC_XFER    3'h1
`define CTS_CYC_SPX     3'h2
`define CTS_CYC_WAIT    3'h1
`define CTS_CYC_ZC_PZ   3'h3
`define CTS_CYC_ZC_REG  3'h1
`define CTS_CYC_ZC_OF1  3'h3
`define CTS_CYC_ZC_NOF  3'h2
`define CTS_CYC_ZC_SO1  3'h4
`define CTS_CYC_LD_FUL  3'h4
`define CTS_CYC_LD_OF2  3'h4
`define CTS_CYC_LD_SO2  3'h5
`define CTS_CYC_LD_IXP  3'h2
`define CTS_CYC_LD_IX1P 3'h3
`define CTS_CYC_MOV     3'h4
`define CTS_CYC_BRANCH  3'h5
// Flag positions; bits 6 and 5 always read as one.
`define CTS_FLG_V       7
`define CTS_FLG_I       3
`define CTS_FLG_N       2
`define CTS_FLG_Z       1
`define CTS_FLG_ONES    8'h60
// Reset values.
`define CTS_RST_SP      16'h00FF
`define CTS_RST_FLG     8'h68
// Register offsets on the bus.
`define CTS_REG_CTRL    16'h0000
`define CTS_REG_STATUS  16'h0004
`define CTS_REG_PC      16'h0008
`define CTS_REG_ACC     16'h000C
`define CTS_REG_INDEX   16'h0010
`define CTS_REG_SP      16'h0014
`define CTS_REG_FLG     16'h0018
`define CTS_MEM_BASE    16'h0400
// Control bits.
`define CTS_CTRL_START  0
`define CTS_CTRL_STOP   1
`define CTS_CTRL_RESUME 2
`endif

//--- common/cts_pkg.sv
// Types shared by the core and its memory.
// Assumes cts_cfg.svh sits on the include path.
`include "cts_cfg.svh"
package cts_pkg;
   // Run state of the core.
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT} cts_state_t;
   // One memory write request.
   typedef struct packed {
      logic        en;
      logic [15:0] addr;
      logic [7:0]  data;
   } cts_wr_t;
endpackage : cts_pkg

//--- hdl/cts_core.sv
// Small processor core: transfers, zero-compare, wait, addressing modes.
// Assumes an APB master; program memory is internal and bus-loaded.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module cts_core
   import cts_pkg::*;
#(
   parameter int MEM_DEPTH = 256
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             coreRunning
);
   cts_state_t          state_r;
   logic [2:0]          cnt_r;
   logic [15:0]         pc_r, pcSet_r, hx_r, sp_r;
   logic [7:0]          acc_r, flg_r;
   logic                illegal_r;
   logic [5:0][15:0]    rdAddr;
   logic [5:0][7:0]     rdData;
   cts_wr_t             wr;
   logic [7:0]          b0, b1, b2, b3, dRd, op, o1, o2, brOff;
   logic                pfx;
   logic [8:0]          key;
   logic [2:0]          len, cyc;
   logic [15:0]         ea, wrAddr, hxN, spN, nxtPc, memOff;
   logic [7:0]          aN, ccN, wrData, tv;
   logic                wrEn, halt, bad, brTake, tst, bitVal;
   logic                commit, apbDone, apbWr, memHit, busy;
   logic                ctrlStart, ctrlStop, ctrlResume;
   logic [31:0]         rdVal;
   logic                errVal;

   // Sets N and Z from a value and clears V; H, I and C are kept.
   function automatic logic [7:0] nzv(input logic [7:0] c,
                                      input logic [7:0] v);
      logic [7:0] r;
      r = c;
      r[`CTS_FLG_N] = v[7];
      r[`CTS_FLG_Z] = (v == 8'h00);
      r[`CTS_FLG_V] = 1'b0;
      return r;
   endfunction : nzv

   // Page-zero location: high byte forced to zero.
   function automatic logic [15:0] pz(input logic [7:0] a);
      return {8'h00, a};
   endfunction : pz

   assign rdAddr[0] = pc_r;
   assign rdAddr[1] = pc_r + 16'h0001;
   assign rdAddr[2] = pc_r + 16'h0002;
   assign rdAddr[3] = pc_r + 16'h0003;
   assign rdAddr[4] = ea;
   assign rdAddr[5] = {2'b00, memOff[15:2]};
   assign b0  = rdData[0];
   assign b1  = rdData[1];
   assign b2  = rdData[2];
   assign b3  = rdData[3];
   assign dRd = rdData[4];

   // Prefixed forms shift every field by one byte.
   assign pfx = (b0 == `CTS_OP_PREFIX);
   assign op  = pfx ? b1 : b0;
   assign o1  = pfx ? b2 : b1;
   assign o2  = pfx ? b3 : b2;
   assign key = {pfx, op};

   // Decode and execute the instruction at the program counter.
   always_comb begin
      len = 3'h1;
      cyc = `CTS_CYC_XFER;
      ea = 16'h0000;
      wrEn = 1'b0;
      wrAddr = 16'h0000;
      wrData = 8'h00;
      aN = acc_r;
      hxN = hx_r;
      spN = sp_r;
      ccN = flg_r;
      halt = 1'b0;
      bad = 1'b0;
      brTake = 1'b0;
      brOff = 8'h00;
      tst = 1'b0;
      tv = 8'h00;
      bitVal = 1'b0;
      case (key)
         {1'b0, `CTS_OP_TAP}: begin
            ccN = acc_r | `CTS_FLG_ONES;
            cyc = `CTS_CYC_TAP;
         end
         {1'b0, `CTS_OP_F2A}: aN = flg_r;
         {1'b0, `CTS_OP_A2X}: hxN = {hx_r[15:8], acc_r};
         {1'b0, `CTS_OP_X2A}: aN = hx_r[7:0];
         {1'b0, `CTS_OP_S2X}: begin
            hxN = sp_r + 16'h0001;
            cyc = `CTS_CYC_SPX;
         end
         {1'b0, `CTS_OP_X2S}: begin
            spN = hx_r - 16'h0001;
            cyc = `CTS_CYC_SPX;
         end
         {1'b0, `CTS_OP_WAIT}: begin
            ccN[`CTS_FLG_I] = 1'b0;
            halt = 1'b1;
            cyc = `CTS_CYC_WAIT;
         end
         {1'b0, `CTS_OP_ZC_PZ}: begin
            ea = pz(o1);
            len = 3'h2;
            tst = 1'b1;
            tv = dRd;
            cyc = `CTS_CYC_ZC_PZ;
         end
         {1'b0, `CTS_OP_ZC_A}: begin
            tst = 1'b1;
            tv = acc_r;
            cyc = `CTS_CYC_ZC_REG;
         end
         {1'b0, `CTS_OP_ZC_X}: begin
            tst = 1'b1;
            tv = hx_r[7:0];
            cyc = `CTS_CYC_ZC_REG;
         end
         {1'b0, `CTS_OP_ZC_OF1}: begin
            ea = hx_r + {8'h00, o1};
            len = 3'h2;
            tst = 1'b1;
            tv = dRd;
            cyc = `CTS_CYC_ZC_OF1;
         end
         {1'b0, `CTS_OP_ZC_NOF}: begin
            ea = hx_r;
            tst = 1'b1;
            tv = dRd;
            cyc = `CTS_CYC_ZC_NOF;
         end
         {1'b1, `CTS_OP_ZC_SO1}: begin
            ea = sp_r + {8'h00, o1};
            len = 3'h3;
            tst = 1'b1;
            tv = dRd;
            cyc = `CTS_CYC_ZC_SO1;
         end
         {1'b0, `CTS_OP_LD_FUL}: begin
            ea = {o1, o2};
            len = 3'h3;
            aN = dRd;
            ccN = nzv(flg_r, dRd);
            cyc = `CTS_CYC_LD_FUL;
         end
         {1'b0, `CTS_OP_LD_OF2}: begin
            ea = hx_r + {o1, o2};
            len = 3'h3;
            aN = dRd;
            ccN = nzv(flg_r, dRd);
            cyc = `CTS_CYC_LD_OF2;
         end
         {1'b1, `CTS_OP_LD_SO2}: begin
            ea = sp_r + {o1, o2};
            len = 3'h4;
            aN = dRd;
            ccN = nzv(flg_r, dRd);
            cyc = `CTS_CYC_LD_SO2;
         end
         {1'b0, `CTS_OP_LD_IXP}: begin
            ea = hx_r;
            hxN = hx_r + 16'h0001;
            aN = dRd;
            ccN = nzv(flg_r, dRd);
            cyc = `CTS_CYC_LD_IXP;
         end
         {1'b0, `CTS_OP_LD_IX1P}: begin
            ea = hx_r + {8'h00, o1};
            hxN = hx_r + 16'h0001;
            len = 3'h2;
            aN = dRd;
            ccN = nzv(flg_r, dRd);
            cyc = `CTS_CYC_LD_IX1P;
         end
         {1'b0, `CTS_OP_MOV_PP}: begin
            ea = pz(o1);
            wrEn = 1'b1;
            wrAddr = pz(o2);
            wrData = dRd;
            len = 3'h3;
            cyc = `CTS_CYC_MOV;
         end
         {1'b0, `CTS_OP_MOV_LP}: begin
            wrEn = 1'b1;
            wrAddr = pz(o2);
            wrData = o1;
            len = 3'h3;
            cyc = `CTS_CYC_MOV;
         end
         {1'b0, `CTS_OP_MOV_IXPD}: begin
            ea = hx_r;
            wrEn = 1'b1;
            wrAddr = pz(o1);
            wrData = dRd;
            hxN = hx_r + 16'h0001;
            len = 3'h2;
            cyc = `CTS_CYC_MOV;
         end
         {1'b0, `CTS_OP_MOV_DIXP}: begin
            ea = pz(o1);
            wrEn = 1'b1;
            wrAddr = hx_r;
            wrData = dRd;
            hxN = hx_r + 16'h0001;
            len = 3'h2;
            cyc = `CTS_CYC_MOV;
         end
         {1'b0, `CTS_OP_CBEQ}: begin
            ea = pz(o1);
            brOff = o2;
            brTake = (acc_r == dRd);
            len = 3'h3;
            cyc = `CTS_CYC_BRANCH;
         end
         default: begin
            if (!pfx && op[7:4] == 4'h0) begin
               // Bit test and branch: odd opcodes branch on a clear bit.
               ea = pz(o1);
               brOff = o2;
               bitVal = dRd[op[3:1]];
               brTake = op[0] ? !bitVal : bitVal;
               len = 3'h3;
               cyc = `CTS_CYC_BRANCH;
            end else begin
               bad = 1'b1;
            end
         end
      endcase
      if (tst) begin
         ccN = nzv(flg_r, tv - 8'h00);
      end
   end

   // Displacement is signed and counts from the next instruction.
   assign nxtPc = pc_r + {13'h0000, len}
                + (brTake ? {{8{brOff[7]}}, brOff} : 16'h0000);

   // Bus-side decode; pready comes one cycle into the access phase.
   assign memOff  = paddr - `CTS_MEM_BASE;
   assign memHit  = (paddr >= `CTS_MEM_BASE)
                 && (memOff[15:2] < 14'(MEM_DEPTH));
   assign busy    = (state_r == ST_RUN);
   assign apbDone = psel && penable && pready;
   assign apbWr   = apbDone && pwrite && !pslverr;
   assign ctrlStart  = apbWr && (paddr == `CTS_REG_CTRL)
                    && pwdata[`CTS_CTRL_START];
   assign ctrlStop   = apbWr && (paddr == `CTS_REG_CTRL)
                    && pwdata[`CTS_CTRL_STOP];
   assign ctrlResume = apbWr && (paddr == `CTS_REG_CTRL)
                    && pwdata[`CTS_CTRL_RESUME];
   assign commit  = busy && (cnt_r == 3'h0) && !bad && !ctrlStop;

   // Read data and error for the current address.
   always_comb begin
      rdVal = 32'h0000_0000;
      errVal = 1'b0;
      case (paddr)
         `CTS_REG_CTRL:   rdVal = {31'h0000_0000, busy};
         `CTS_REG_STATUS: rdVal = {29'h0000_0000, illegal_r,
                                   state_r == ST_WAIT, busy};
         `CTS_REG_PC:     rdVal = {16'h0000, pc_r};
         `CTS_REG_ACC:    rdVal = {24'h00_0000, acc_r};
         `CTS_REG_INDEX:  rdVal = {16'h0000, hx_r};
         `CTS_REG_SP:     rdVal = {16'h0000, sp_r};
         `CTS_REG_FLG:    rdVal = {24'h00_0000, flg_r};
         default: begin
            if (memHit) begin
               rdVal = {24'h00_0000, rdData[5]};
            end
            errVal = !memHit;
         end
      endcase
      // Core state may not be written while instructions run.
      if (pwrite && busy && paddr != `CTS_REG_CTRL) begin
         errVal = 1'b1;
      end
   end

   // APB answer: one wait state, data and error held with pready.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= errVal;
         prdata  <= pwrite ? 32'h0000_0000 : rdVal;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   // Run control and the stall counter that stretches each instruction.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= ST_IDLE;
         cnt_r       <= 3'h0;
         coreRunning <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (ctrlStart) begin
                  state_r     <= ST_RUN;
                  coreRunning <= 1'b1;
               end
            end
            ST_RUN: begin
               if (ctrlStop || (cnt_r == 3'h0 && bad)) begin
                  state_r     <= ST_IDLE;
                  coreRunning <= 1'b0;
                  cnt_r       <= 3'h0;
               end else if (cnt_r != 3'h0) begin
                  cnt_r <= cnt_r - 3'h1;
               end else if (halt) begin
                  state_r     <= ST_WAIT;
                  coreRunning <= 1'b0;
               end else begin
                  cnt_r <= cyc - 3'h1;
               end
            end
            ST_WAIT: begin
               if (ctrlStop) begin
                  state_r <= ST_IDLE;
               end else if (ctrlStart || ctrlResume) begin
                  state_r     <= ST_RUN;
                  coreRunning <= 1'b1;
               end
            end
            default: begin
               state_r     <= ST_IDLE;
               coreRunning <= 1'b0;
            end
         endcase
      end
   end

   // Illegal opcode flag; a new start clears it, a fresh fault wins.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         illegal_r <= 1'b0;
      end else if (busy && cnt_r == 3'h0 && bad) begin
         illegal_r <= 1'b1;
      end else if (ctrlStart) begin
         illegal_r <= 1'b0;
      end
   end

   // Processor registers: committed by instructions, or written by bus.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pc_r    <= 16'h0000;
         pcSet_r <= 16'h0000;
         acc_r   <= 8'h00;
         hx_r    <= 16'h0000;
         sp_r    <= `CTS_RST_SP;
         flg_r   <= `CTS_RST_FLG;
      end else if (commit) begin
         pc_r  <= nxtPc;
         acc_r <= aN;
         hx_r  <= hxN;
         sp_r  <= spN;
         flg_r <= ccN;
      end else if (ctrlStart) begin
         pc_r <= pcSet_r;
      end else if (apbWr) begin
         case (paddr)
            `CTS_REG_PC:    pcSet_r <= pwdata[15:0];
            `CTS_REG_ACC:   acc_r   <= pwdata[7:0];
            `CTS_REG_INDEX: hx_r    <= pwdata[15:0];
            `CTS_REG_SP:    sp_r    <= pwdata[15:0];
            `CTS_REG_FLG:   flg_r   <= pwdata[7:0] | `CTS_FLG_ONES;
            default:        pc_r    <= pc_r;
         endcase
      end
   end

   // One memory write per cycle: bus writes are refused while running.
   assign wr.en   = (commit && wrEn) || (apbWr && memHit);
   assign wr.addr = commit ? wrAddr : {2'b00, memOff[15:2]};
   assign wr.data = commit ? wrData : pwdata[7:0];

   cts_mem #(
      .DEPTH (MEM_DEPTH),
      .NRD   (6)
   ) uMem (
      .clock  (clock),
      .rdAddr (rdAddr),
      .rdData (rdData),
      .wr     (wr)
   );
endmodule : cts_core

//--- hdl/cts_mem.sv
// Byte memory with several asynchronous read ports and one write port.
// Assumes one writer per cycle; addresses wrap on the depth.
`timescale 1ns/1ps
module cts_mem
   import cts_pkg::*;
#(
   parameter int DEPTH = 256,
   parameter int NRD   = 6
) (
   input  wire logic                  clock,
   input  wire logic [NRD-1:0][15:0]  rdAddr,
   output logic      [NRD-1:0][7:0]   rdData,
   input  wire cts_wr_t               wr
);
   localparam int AW = $clog2(DEPTH);
   logic [7:0] mem_r [DEPTH];

   // Reads are combinational so an instruction sees all its bytes at once.
   genvar g;
   for (g = 0; g < NRD; g++) begin : gRd
      assign rdData[g] = mem_r[rdAddr[g][AW-1:0]];
   end

   // Memory is not reset; software loads it before starting the core.
   always_ff @(posedge clock) begin
      if (wr.en) begin
         mem_r[wr.addr[AW-1:0]] <= wr.data;
      end
   end
endmodule : cts_mem

//--- tb/cts_core_props.sv
// Concurrent checks on the bus port and run flag of the core.
// Assumes it is bound to cts_core and sees only that module's ports.
`timescale 1ns/1ps
module cts_core_props
   import cts_pkg::*;
#(
   parameter int MEM_DEPTH = 256
) (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        coreRunning
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic ctrlWr;
   logic hole;
   // An accepted control write, and a bus address that maps to nothing.
   assign ctrlWr = psel && penable && pready && pwrite && (paddr == 16'h0000);
   assign hole   = (paddr > 16'h0018 && paddr < 16'h0400) ||
                   (paddr >= 16'h0800);
   a_ready_one_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_ready_after_access: assert property
      (psel && penable && !pready |=> pready)
      else $error("access phase not answered in one cycle");
   a_ready_needs_access: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero between answers");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_unmapped_err: assert property (pready && hole |-> pslverr)
      else $error("unmapped address accepted");
   a_busy_write_err: assert property
      (pready && pwrite && paddr != 16'h0000 && $past(coreRunning)
       |-> pslverr)
      else $error("write accepted while running");
   a_run_needs_start: assert property
      ($rose(coreRunning) |-> $past(ctrlWr && (pwdata[0] || pwdata[2])))
      else $error("core ran without a start");
   a_stop_goes_idle: assert property
      (ctrlWr && pwdata[1] && !pwdata[0] && !pwdata[2] |=> !coreRunning)
      else $error("stop did not halt the core");
   c_start: cover property (ctrlWr && pwdata[0]);
   c_refused: cover property (pready && pslverr);
   c_halted: cover property ($fell(coreRunning));
endmodule : cts_core_props

bind cts_core cts_core_props #(.MEM_DEPTH(MEM_DEPTH)) cts_core_props_inst (
   .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .coreRunning(coreRunning));

//--- tb/cts_core_tb_top.sv
// Self-checking bench: small programs loaded and run over the bus.
// Assumes cts_core with its bus-loaded memory and cts_cfg.svh included.
`timescale 1ns/1ps
`include "cts_cfg.svh"
module cts_core_tb_top;
   import cts_pkg::*;
   typedef struct {logic [31:0] d; logic e; bit c;} cts_note_t;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, coreRunning;
   cts_note_t   notes[$], n;
   int          mismatches = 0, compares = 0, ticks = 0, runCyc = 0, cyc;
   logic [7:0]  v, code[$];
   int          tcyc[6] = '{4, 2, 2, 4, 3, 5};
   int          lcyc[10] = '{5, 5, 6, 3, 4, 3, 5, 5, 5, 5};
   logic [15:0] thx[10] = '{16'h80, 16'h80, 16'h80, 16'h90, 16'h80,
                            16'hFFFF, 16'h80, 16'h80, 16'h90, 16'hA0};
   logic [15:0] ehx[10] = '{16'h80, 16'h80, 16'h80, 16'h91, 16'h81,
                            16'h0, 16'h80, 16'h80, 16'h91, 16'hA1};
   localparam logic [15:0] M90 = 16'h0640, MA0 = 16'h0680, MFF = 16'h07FC;
   always #4 clock = ~clock;
   cts_core #(.MEM_DEPTH(256)) cts_core_inst (.clock(clock), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .coreRunning(coreRunning));
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [31:0] g, input logic [31:0] x,
                      input string m);
      compares++;
      if (g !== x) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
      end
   endtask : cmp
   // One transfer; held until ready is seen, then an idle edge follows so
   // that no strobe is assigned twice in one time step.
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] d, input cts_note_t nt);
      int k;
      notes.push_back(nt);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
                     input logic e);
      apb(1'b1, a, d, '{32'h0, e, 1'b0});
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, '{x, 1'b0, 1'b1});
   endtask : rd
   // Loads the program at zero, starts it and, unless hold is set, times it until it halts.
   task automatic run(input bit hold);
      int k;
      foreach (code[i]) wr(16'h0400 + 16'(4 * i), {24'h0, code[i]}, 1'b0);
      wr(`CTS_REG_PC, 32'h0, 1'b0);
      runCyc = 0;
      wr(`CTS_REG_CTRL, 32'h1, 1'b0);
      if (hold) return;
      k = 0;
      while (coreRunning !== 1'b0 && k < 500) begin
         @(posedge clock);
         k++;
      end
      cmp(runCyc, cyc, "cycles");
   endtask : run
   // Every bus answer is matched against the oldest expectation.
   always @(posedge clock) begin
      ticks++;
      if (coreRunning === 1'b1) runCyc++;
      if (ticks == 20000) begin
         mismatches++;
         report_and_stop();
      end
      if (pready === 1'b1) begin
         n = notes.pop_front();
         cmp({31'h0, pslverr}, {31'h0, n.e}, "error flag");
         if (n.c) cmp(prdata, n.d, "read data");
      end
   end
   initial begin
      void'($urandom(32'h7979_4e0b));
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      wr(`CTS_REG_ACC, 32'h9D, 1'b0);
      wr(`CTS_REG_INDEX, 32'h1234, 1'b0);
      code = '{8'h84, 8'h85, 8'h97, 8'h8F};
      cyc = 5;
      run(1'b0);
      rd(`CTS_REG_FLG, 32'hF5);
      rd(`CTS_REG_ACC, 32'hFD);
      rd(`CTS_REG_INDEX, 32'h12FD);
      rd(`CTS_REG_STATUS, 32'h2);
      $display("test transfers done");
      wr(`CTS_REG_SP, 32'h1233, 1'b0);
      wr(`CTS_REG_INDEX, 32'h0300, 1'b0);
      wr(`CTS_REG_ACC, 32'h55, 1'b0);
      wr(`CTS_REG_FLG, 32'h0, 1'b0);
      code = '{8'h94, 8'h95, 8'h9F, 8'h8F};
      cyc = 6;
      run(1'b0);
      rd(`CTS_REG_SP, 32'h02FF);
      rd(`CTS_REG_INDEX, 32'h0300);
      rd(`CTS_REG_ACC, 32'h0);
      rd(`CTS_REG_FLG, 32'h60);
      $display("test stack transfers done");
      // Zero-compare in each form; flags start with V, H, I, N and C set.
      for (int i = 0; i < 6; i++) begin
         v = (i == 1) ? 8'h00 : 8'($urandom);
         wr(M90, {24'h0, v}, 1'b0);
         wr(`CTS_REG_ACC, (i == 1) ? {24'h0, v} : 32'h1, 1'b0);
         wr(`CTS_REG_INDEX, (i == 2) ? {24'h0, v} :
            (i == 4) ? 32'h90 : 32'h80, 1'b0);
         wr(`CTS_REG_SP, 32'h80, 1'b0);
         wr(`CTS_REG_FLG, 32'h9D, 1'b0);
         case (i)
            0: code = '{8'h3D, 8'h90, 8'h8F};
            1: code = '{8'h4D, 8'h8F};
            2: code = '{8'h5D, 8'h8F};
            3: code = '{8'h6D, 8'h10, 8'h8F};
            4: code = '{8'h7D, 8'h8F};
            default: code = '{8'h9E, 8'h6D, 8'h10, 8'h8F};
         endcase
         cyc = tcyc[i];
         run(1'b0);
         rd(`CTS_REG_FLG,
            {24'h0, 8'h71 | {5'h0, v[7], v == 8'h0, 1'b0}});
      end
      $display("test zero compare done");
      // Loads then moves; only the load with index FFFF places the operand at a wrapped location.
      for (int i = 0; i < 10; i++) begin
         v = 8'($urandom);
         wr(M90, {24'h0, v}, 1'b0);
         wr(MFF, {24'h0, v}, 1'b0);
         wr(MA0, {24'h0, ~v}, 1'b0);
         wr(`CTS_REG_SP, 32'h70, 1'b0);
         wr(`CTS_REG_INDEX, {16'h0, thx[i]}, 1'b0);
         case (i)
            0: code = '{8'hC6, 8'h00, 8'h90, 8'h8F};
            1: code = '{8'hD6, 8'h00, 8'h10, 8'h8F};
            2: code = '{8'h9E, 8'hD6, 8'h00, 8'h20, 8'h8F};
            3, 5: code = '{8'hC8, 8'h8F};
            4: code = '{8'hC9, 8'h10, 8'h8F};
            6: code = '{8'h4E, 8'h90, 8'hA0, 8'h8F};
            7: code = '{8'h6E, 8'h5A, 8'hA0, 8'h8F};
            8: code = '{8'h7E, 8'hA0, 8'h8F};
            default: code = '{8'h5E, 8'h90, 8'h8F};
         endcase
         cyc = lcyc[i];
         run(1'b0);
         rd(`CTS_REG_INDEX, {16'h0, ehx[i]});
         if (i < 6)
            rd(`CTS_REG_ACC, {24'h0, v});
         else
            rd(MA0, (i == 7) ? 32'h5A : {24'h0, v});
      end
      $display("test addressing modes done");
      for (int j = 0; j < 2; j++) begin
         v = 8'($urandom);
         wr(M90, {24'h0, v}, 1'b0);
         wr(`CTS_REG_ACC, {24'h0, (j == 0) ? v : ~v}, 1'b0);
         code = '{8'h31, 8'h90, 8'h04, 8'h8F, 8'h8F, 8'h8F, 8'h8F, 8'h8F};
         cyc = 6;
         run(1'b0);
         rd(`CTS_REG_PC, (j == 0) ? 32'h8 : 32'h4);
      end
      $display("test branch done");
      // A branch onto itself keeps the core busy for the refusal checks.
      wr(`CTS_REG_ACC, {24'h0, v}, 1'b0);
      code = '{8'h31, 8'h90, 8'hFD};
      run(1'b1);
      wr(`CTS_REG_ACC, 32'h11, 1'b1);
      wr(`CTS_REG_CTRL, 32'h2, 1'b0);
      rd(`CTS_REG_STATUS, 32'h0);
      rd(`CTS_REG_ACC, {24'h0, v});
      apb(1'b0, 16'h001C, 32'h0, '{32'h0, 1'b1, 1'b0});
      apb(1'b0, 16'h0800, 32'h0, '{32'h0, 1'b1, 1'b0});
      $display("test refusal and stop done");
      report_and_stop();
   end
endmodule : cts_core_tb_top
